// File: hdl/sacw_core.sv
// sacw_core: attenuation state selection from the control pins
// assumes all pins are asynchronous to i_ref_clk and change slowly
// assumes each pin pulse stays three reference clocks high and low
// assumes the far side sets the selectors before the first word
`timescale 1ns/100ps

module sacw_core
(
    input  wire logic                i_ref_clk,
    input  wire logic                i_rst_b,
    input  wire sacw_pkg::sacw_pins_t i_pins,
    output logic [5:0]               o_atten_state,
    output logic                     o_word_seen
);

    // ========================================================================
    // two-stage synchroniser; stage one feeds stage two only
    sacw_pkg::sacw_pins_t meta_q;
    sacw_pkg::sacw_pins_t sync_q;
    sacw_pkg::sacw_pins_t prev_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= i_pins;
            sync_q <= meta_q;
        end
    end

    // ========================================================================
    // history flop; resets to the idle low of clock and latch, so no
    // false edge follows reset
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            prev_q <= '0;
        else
            prev_q <= sync_q;
    end

    // ========================================================================
    // edge detection on synchronised pins
    logic clk_rise;
    logic latch_rise;
    logic par_mode;
    logic [5:0] pup_word;

    assign clk_rise   = sync_q.serial_clk & ~prev_q.serial_clk;
    assign latch_rise = sync_q.word_latch & ~prev_q.word_latch;
    assign par_mode   = ~sync_q.ser_par_sel;

    // power-up selector decode
    always_comb
    begin
        case ({sync_q.powerup_sel_a, sync_q.powerup_sel_b})
            2'b11:   pup_word = sacw_pkg::SACW_PUP_MAX;
            2'b10:   pup_word = sacw_pkg::SACW_PUP_SIXTEEN;
            2'b01:   pup_word = sacw_pkg::SACW_PUP_EIGHT;
            default: pup_word = sacw_pkg::SACW_REF_LOSS;
        endcase
    end

    // ========================================================================
    // serial shift register, msb first; only shifts in serial mode
    // limitation: a clock rise in the cycle of a latch rise shifts after
    // the transfer, so the host must keep the two apart
    logic [5:0] shift_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            shift_q <= sacw_pkg::SACW_RST_STATE;
        else if (!par_mode && clk_rise)
            shift_q <= {shift_q[4:0], sync_q.serial_data};
    end

    // ========================================================================
    // first-word flag: once a word lands the selectors stop acting
    logic word_seen_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            word_seen_q <= 1'b0;
        else if (latch_rise || (par_mode && sync_q.word_latch))
            word_seen_q <= 1'b1;
    end

    // ========================================================================
    // applied state; code is the sum of the weighted bits, all 64 valid
    // priority: parallel word, serial transfer, then the power-up table;
    // the table stops once a word lands, so late selector moves are inert
    logic [5:0] state_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state_q <= sacw_pkg::SACW_RST_STATE;
        else if (par_mode && sync_q.word_latch)
            state_q <= sync_q.parallel_control_word;
        else if (!par_mode && latch_rise)
            state_q <= shift_q;
        else if (!word_seen_q)
            state_q <= pup_word;
    end

    assign o_atten_state = state_q;
    assign o_word_seen   = word_seen_q;

    // ========================================================================
    // checks
    // a word seen with the latch high lands on the next edge
    chk_direct_follow: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (par_mode && sync_q.word_latch)
        |=> (state_q == $past(sync_q.parallel_control_word)))
        else $error("direct parallel word not applied");

    // selectors act in parallel mode only until the first word
    chk_pup_table: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (par_mode && !sync_q.word_latch && !word_seen_q && !latch_rise)
        |=> (state_q == $past(pup_word)))
        else $error("power-up selector state wrong");

    // selector state also holds in serial mode before a word
    chk_pup_serial: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!par_mode && !latch_rise && !word_seen_q)
        |=> (state_q == $past(pup_word)))
        else $error("power-up state wrong in serial mode");

    // serial latch rise moves the shifted word across
    chk_serial_xfer: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!par_mode && latch_rise) |=> (state_q == $past(shift_q)))
        else $error("serial word not transferred");

    // in serial mode, no latch rise, no change once a word is in
    chk_serial_hold: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!par_mode && !latch_rise && word_seen_q) |=> $stable(state_q))
        else $error("state moved in serial mode without latch");

    // latched parallel: latch low keeps the captured word
    chk_latched_hold: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (par_mode && !sync_q.word_latch && word_seen_q)
        |=> $stable(state_q))
        else $error("state moved in parallel mode with latch low");

    // serial clock is ignored in parallel mode
    chk_par_no_shift: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        par_mode |=> $stable(shift_q))
        else $error("shift register moved in parallel mode");

    // each clock rise in serial mode adds one bit at the lsb end
    chk_shift_in: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!par_mode && clk_rise)
        |=> (shift_q == {$past(shift_q[4:0]), $past(sync_q.serial_data)}))
        else $error("serial bit not shifted in");

    // without a clock rise the shift register holds
    chk_shift_hold: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !clk_rise |=> $stable(shift_q))
        else $error("shift register moved without clock rise");

    // any word sets the flag on the next edge
    chk_seen_sets: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (latch_rise || (par_mode && sync_q.word_latch))
        |=> word_seen_q)
        else $error("first word flag not set");

    // only a word may set the flag
    chk_seen_needs_word: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!word_seen_q && !latch_rise
        && !(par_mode && sync_q.word_latch))
        |=> !word_seen_q)
        else $error("first word flag set without a word");

    // flag sticks until reset
    chk_seen_sticky: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        word_seen_q |=> word_seen_q)
        else $error("first word flag dropped");

    // ========================================================================
    // cover points for the main scenarios
    cov_direct: cover property (@(posedge i_ref_clk)
        par_mode && sync_q.word_latch
        && sync_q.parallel_control_word == 6'h3F);
    cov_serial: cover property (@(posedge i_ref_clk)
        !par_mode && latch_rise);
    cov_serial_first: cover property (@(posedge i_ref_clk)
        !par_mode && latch_rise && !word_seen_q);
    cov_pup_max: cover property (@(posedge i_ref_clk)
        !word_seen_q && state_q == sacw_pkg::SACW_PUP_MAX);
    cov_pup_ignored: cover property (@(posedge i_ref_clk)
        word_seen_q && par_mode && !sync_q.word_latch
        && sync_q.powerup_sel_a && sync_q.powerup_sel_b);

endmodule

// File: hdl/sacw_pkg.sv
// sacw_pkg: constants and carrier types for the step attenuator control word
// assumes nothing beyond a SystemVerilog compiler
package sacw_pkg;

    // ========================================================================
    // widths and codes
    localparam int          SACW_WORD_W     = 6;
    localparam logic [5:0]  SACW_REF_LOSS   = 6'h00; // reference loss
    localparam logic [5:0]  SACW_PUP_MAX    = 6'h3F; // 31.5 dB
    localparam logic [5:0]  SACW_PUP_SIXTEEN = 6'h20; // 16 dB
    localparam logic [5:0]  SACW_PUP_EIGHT  = 6'h10; // 8 dB
    localparam logic [5:0]  SACW_RST_STATE  = 6'h00;

    // ========================================================================
    // pin group from the control connector
    typedef struct packed {
        logic       ser_par_sel;   // low parallel, high serial
        logic       word_latch;
        logic       serial_clk;
        logic       serial_data;
        logic       powerup_sel_a;
        logic       powerup_sel_b;
        logic [5:0] parallel_control_word;
    } sacw_pins_t;

endpackage

// File: verif/sacw_host_model.sv
// sacw_host_model: host logic driving the attenuator control pins
// assumes a free-running clock; pins change 1 ns after its rise
`timescale 1ns/100ps

module sacw_host_model
(
    input  wire logic            i_clk,
    output sacw_pkg::sacw_pins_t o_pins
);
    // ========================================================================
    // pin drivers; the bench's first call sets every pin at time 0
    // phases of 4 cycles clear the 3-clock minimum with margin
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // selectors set with latch low, as before supply is applied
    task automatic pup(input logic a, input logic b, input logic ser);
        o_pins = '{ser, 1'b0, 1'b0, 1'b0, a, b, 6'h00};
    endtask
    // selectors high on purpose: they must be ignored here
    task automatic direct(input logic [5:0] w);
        o_pins = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, w};
    endtask
    // msb first; parallel lines carry junk to show they are unused
    // one whole-pin write per step, data moves with the clock fall
    task automatic shift(input logic [5:0] w);
        sacw_pkg::sacw_pins_t p;
        p = '{1'b1, 1'b0, 1'b0, w[5], 1'b0, 1'b0, ~w};
        o_pins = p;
        for (int i = 5; i >= 0; i--)
        begin
            hold(4);
            p.serial_clk = 1'b1;
            o_pins = p;
            hold(4);
            p.serial_clk = 1'b0;
            p.serial_data = (i > 0) ? w[i - 1] : ~w[0]; // no stale level
            o_pins = p;
        end
        hold(4);
        p.word_latch = 1'b1;
        o_pins = p;
        hold(4);
        p.word_latch = 1'b0;
        o_pins = p;
    endtask
endmodule

// File: verif/tb.sv
// tb: self-checking bench for sacw_core
// assumes the host model drives every pin of the core
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end

module tb;
    logic                 clk = 1'b0;
    logic                 rst_b = 1'b0;
    sacw_pkg::sacw_pins_t pins;
    logic [5:0]           atten;
    logic                 seen;
    int                   fails = 0;
    int                   n_compared = 0;
    logic [5:0]           pups [5] = '{sacw_pkg::SACW_REF_LOSS,
        sacw_pkg::SACW_PUP_EIGHT, sacw_pkg::SACW_PUP_SIXTEEN,
        sacw_pkg::SACW_PUP_MAX, sacw_pkg::SACW_PUP_MAX};
    logic [5:0]           words [9] = '{6'h00, 6'h01, 6'h02, 6'h04,
        6'h08, 6'h10, 6'h20, 6'h3F, 6'h2A};

    // ========================================================================
    // clock, parts and verdict
    always #5 clk = ~clk;
    sacw_host_model host (.i_clk(clk), .o_pins(pins));
    sacw_core dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_pins(pins),
        .o_atten_state(atten), .o_word_seen(seen));
    task automatic complete_run();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // whole run needs about 270 cycles; the limit allows 20000
    initial
    begin
        #200000;
        fails++;
        complete_run();
    end

    // ========================================================================
    // tests
    initial
    begin
        // power-up table, last pass in serial mode
        for (int k = 0; k < 5; k++)
        begin
            rst_b = 1'b0;
            host.pup(k[1] | k[2], k[0] | k[2], k[2]);
            repeat (10) @(posedge clk);
            #1 rst_b = 1'b1;
            host.hold(6);
            `CHK(atten, pups[k])
            `CHK(seen, 1'b0)
        end
        // first word in serial mode ends the power-up table
        host.shift(6'h15);
        host.hold(6);
        `CHK(atten, 6'h15)
        `CHK(seen, 1'b1)
        host.pup(1'b1, 1'b1, 1'b1);
        host.hold(6);
        `CHK(atten, 6'h15)
        // direct parallel words
        foreach (words[i])
        begin
            host.direct(words[i]);
            host.hold(6);
            `CHK(atten, words[i])
        end
        `CHK(seen, 1'b1)
        // selectors ignored once a word has been applied
        host.pup(1'b1, 1'b1, 1'b0);
        host.hold(6);
        `CHK(atten, 6'h2A)
        host.shift(6'h2D);
        host.hold(6);
        `CHK(atten, 6'h2D)
        complete_run();
    end
endmodule
